// ==== pkg/cmdac_pkg.sv ====
package cmdac_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  SETUP_IDX      = 8'h06;
  localparam logic [7:0]  DIAG_IDX       = 8'h08;
  localparam logic [7:0]  RESULT_IDX     = 8'h09;
  localparam logic [7:0]  IRQ_STAT_IDX   = 8'h0a;
  localparam logic [7:0]  IRQ_EN_IDX     = 8'h0b;
  localparam logic [7:0]  IRQ_CLR_IDX    = 8'h0c;

  // Converter setup field positions
  localparam int          AVG_LSB        = 12;
  localparam int          KICK_BIT       = 11;
  localparam int          GAIN_LSB       = 8;
  localparam int          CLEAR_BIT      = 7;
  localparam int          RES_A_LSB      = 4;
  localparam int          RES_B_LSB      = 2;
  localparam int          RES_2_LSB      = 0;
  localparam logic [15:0] SETUP_RESET    = 16'h0417;

  // Diagnostic switch field positions
  localparam int          FCHK_BIT       = 0;
  localparam int          ODD_T_BIT      = 1;
  localparam int          EVEN_T_BIT     = 2;
  localparam int          ODD_B_BIT      = 3;
  localparam int          EVEN_B_BIT     = 4;

  // Interrupt status bits
  localparam int          IRQ_DONE_BIT   = 0;
  localparam int          IRQ_CLR_BIT    = 1;
  localparam int          IRQ_W          = 2;

  // Largest averaging code; codes above it take one sample
  localparam logic [3:0]  AVG_MAX_CODE   = 4'h8;

  typedef struct packed {
    logic even_balance_probe_switch;
    logic odd_balance_probe_switch;
    logic even_terminal_probe_switch;
    logic odd_terminal_probe_switch;
    logic terminal_fault_check_enable;
  } cmdac_diag_t;

  typedef struct packed {
    logic [2:0] amp_gain_select;
    logic [1:0] first_converter_a_resolution;
    logic [1:0] first_converter_b_resolution;
    logic [1:0] second_converter_resolution;
  } cmdac_cfg_t;

  typedef enum logic {CMDAC_IDLE, CMDAC_RUN} cmdac_state_t;

endpackage : cmdac_pkg

// ==== hdl/cmdac_top.sv ====
`timescale 1ns/1ns
// What this block does
// - Fault check enable bit 0 disables, 1 enables terminal over/undervoltage check.
// - Odd terminal probe bit 0 opens, 1 closes odd terminal switches.
// - Even terminal probe bit 0 opens, 1 closes even terminal switches.
// - Odd balance probe bit 0 opens, 1 closes odd balance switches.
// - Even balance probe bit 0 opens, 1 closes even balance switches.
// - Setup register holds averaging, gain and resolution for all converters.
// - Kickoff bit 11 starts conversion; reads busy flag; bit 7 reads 0.
// - Codes 0001 to 1000 average 2 to 256; others disable averaging.
// - Writing kickoff 1 while idle pulses a start; 0 leaves a running sequence alone.
// - Busy flag reads 1 during a conversion and 0 once complete.
// - Writing charge clear 1 pulses a counter clear; 0 does nothing.
module cmdac_top #(
  parameter int DATA_W = 16
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 sample_valid,
  input  wire logic [DATA_W-1:0]    sample_data,
  input  wire logic [2:0]           amp_gain_report,
  output cmdac_pkg::cmdac_diag_t    diag_sw,
  output cmdac_pkg::cmdac_cfg_t     conv_cfg,
  output logic                      conv_start,
  output logic                      conv_busy,
  output logic      [DATA_W-1:0]    conv_result,
  output logic                      charge_counter_clear,
  output logic                      irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic                    setup_phase;
  logic                    wr_en;
  logic [7:0]              idx;
  logic                    hit_setup;
  logic                    hit_diag;
  logic                    hit_result;
  logic                    hit_stat;
  logic                    hit_en;
  logic                    hit_clr;
  logic                    mapped;
  logic                    wr_setup;
  logic                    wr_diag;
  logic                    kick;
  logic                    cc_clr;

  assign setup_phase = psel && !penable;
  assign wr_en       = psel && penable && pwrite && pready;
  assign idx         = paddr[9:2];
  assign hit_setup   = (paddr[1:0] == 2'h0) && (idx == cmdac_pkg::SETUP_IDX);
  assign hit_diag    = (paddr[1:0] == 2'h0) && (idx == cmdac_pkg::DIAG_IDX);
  assign hit_result  = (paddr[1:0] == 2'h0) && (idx == cmdac_pkg::RESULT_IDX);
  assign hit_stat    = (paddr[1:0] == 2'h0) && (idx == cmdac_pkg::IRQ_STAT_IDX);
  assign hit_en      = (paddr[1:0] == 2'h0) && (idx == cmdac_pkg::IRQ_EN_IDX);
  assign hit_clr     = (paddr[1:0] == 2'h0) && (idx == cmdac_pkg::IRQ_CLR_IDX);
  assign mapped      = (paddr[11:10] == 2'h0) && (hit_setup || hit_diag || hit_result || hit_stat || hit_en || hit_clr);
  assign wr_setup    = wr_en && hit_setup && (paddr[11:10] == 2'h0);
  assign wr_diag     = wr_en && hit_diag && (paddr[11:10] == 2'h0);
  // Kickoff and counter clear are strobes, not stored bits
  assign kick        = wr_setup && pwdata[cmdac_pkg::KICK_BIT];
  assign cc_clr      = wr_setup && pwdata[cmdac_pkg::CLEAR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Stored registers

  logic [3:0]              avg_q;
  cmdac_pkg::cmdac_cfg_t   cfg_q;
  cmdac_pkg::cmdac_diag_t  diag_q;
  logic [2:0]              gain_rpt_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      avg_q <= cmdac_pkg::SETUP_RESET[cmdac_pkg::AVG_LSB +: 4];
      cfg_q <= cmdac_pkg::cmdac_cfg_t'({cmdac_pkg::SETUP_RESET[10:8], cmdac_pkg::SETUP_RESET[5:0]});
    end
    else if (wr_setup)
    begin
      avg_q <= pwdata[cmdac_pkg::AVG_LSB +: 4];
      cfg_q <= cmdac_pkg::cmdac_cfg_t'({pwdata[cmdac_pkg::GAIN_LSB +: 3], pwdata[5:0]});
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      diag_q <= '0;
    else if (wr_diag)
      diag_q <= cmdac_pkg::cmdac_diag_t'(pwdata[4:0]);
  end

  // Gain report comes from the amplifier path; sampled so reads are stable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gain_rpt_q <= 3'h0;
    else
      gain_rpt_q <= amp_gain_report;
  end

  assign diag_sw  = diag_q;
  assign conv_cfg = cfg_q;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer with averaging

  function automatic logic [3:0] avg_shift(input logic [3:0] code);
    avg_shift = (code <= cmdac_pkg::AVG_MAX_CODE) ? code : 4'h0;
  endfunction : avg_shift

  cmdac_pkg::cmdac_state_t state_q;
  logic [3:0]              shift_q;
  logic [8:0]              cnt_q;
  logic [DATA_W+7:0]       acc_q;
  logic [DATA_W-1:0]       result_q;
  logic                    start_q;
  logic                    clear_q;
  logic [8:0]              target;
  logic [DATA_W+7:0]       acc_sum;
  logic                    last_smp;
  logic                    done;

  assign target   = 9'(9'h001 << shift_q);
  assign acc_sum  = acc_q + (DATA_W+8)'(sample_data);
  assign last_smp = (state_q == cmdac_pkg::CMDAC_RUN) && sample_valid && (cnt_q == 9'(target - 9'h001));
  assign done     = last_smp;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q  <= cmdac_pkg::CMDAC_IDLE;
      shift_q  <= 4'h0;
      cnt_q    <= 9'h000;
      acc_q    <= '0;
      result_q <= '0;
    end
    else
    begin
      case (state_q)
        cmdac_pkg::CMDAC_IDLE:
        begin
          // A kickoff while running is ignored: the sequence is not restarted
          if (kick)
          begin
            state_q <= cmdac_pkg::CMDAC_RUN;
            shift_q <= avg_shift(pwdata[cmdac_pkg::AVG_LSB +: 4]);
            cnt_q   <= 9'h000;
            acc_q   <= '0;
          end
        end
        cmdac_pkg::CMDAC_RUN:
        begin
          if (sample_valid)
          begin
            acc_q <= acc_sum;
            cnt_q <= 9'(cnt_q + 9'h001);
            if (last_smp)
            begin
              result_q <= DATA_W'(acc_sum >> shift_q);
              state_q  <= cmdac_pkg::CMDAC_IDLE;
            end
          end
        end
        default:
          state_q <= cmdac_pkg::CMDAC_IDLE;
      endcase
    end
  end

  // Strobes to the measurement path and the charge counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_q <= 1'b0;
      clear_q <= 1'b0;
    end
    else
    begin
      start_q <= kick && (state_q == cmdac_pkg::CMDAC_IDLE);
      clear_q <= cc_clr;
    end
  end

  assign conv_start           = start_q;
  assign conv_busy            = (state_q == cmdac_pkg::CMDAC_RUN);
  assign conv_result          = result_q;
  assign charge_counter_clear = clear_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic [cmdac_pkg::IRQ_W-1:0] stat_q;
  logic [cmdac_pkg::IRQ_W-1:0] en_q;
  logic [cmdac_pkg::IRQ_W-1:0] ev;
  logic [cmdac_pkg::IRQ_W-1:0] clr;
  logic                        irq_q;

  assign ev  = {cc_clr, done};
  assign clr = (wr_en && hit_clr && (paddr[11:10] == 2'h0)) ? pwdata[cmdac_pkg::IRQ_W-1:0] : '0;

  // An event in the clearing cycle survives the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q <= '0;
      en_q   <= '0;
      irq_q  <= 1'b0;
    end
    else
    begin
      stat_q <= (stat_q & ~clr) | ev;
      if (wr_en && hit_en && (paddr[11:10] == 2'h0))
        en_q <= pwdata[cmdac_pkg::IRQ_W-1:0];
      irq_q  <= |(((stat_q & ~clr) | ev) & en_q);
    end
  end

  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data and ready are loaded in the setup cycle, so no wait states

  logic [31:0] rd_mux;
  logic [15:0] setup_rd;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  assign setup_rd = {avg_q, conv_busy, gain_rpt_q, 1'b0, 1'b0, cfg_q[5:0]};
  assign rd_mux   = !mapped   ? 32'h0000_0000 :
                    hit_setup ? {16'h0000, setup_rd} :
                    hit_diag  ? {27'h0000000, diag_q} :
                    hit_result ? 32'(result_q) :
                    hit_stat  ? {30'h00000000, stat_q} :
                    hit_en    ? {30'h00000000, en_q} :
                    32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q  <= (setup_phase && !pwrite) ? rd_mux : 32'h0000_0000;
      pready_q  <= setup_phase;
      pslverr_q <= setup_phase && !mapped;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_setup_kick;
    wr_setup && pwdata[cmdac_pkg::KICK_BIT] && (state_q == cmdac_pkg::CMDAC_IDLE);
  endsequence

  sequence s_busy_start;
    conv_busy && conv_start;
  endsequence

  a_fault_check_follow: assert property (@(posedge pclk) disable iff (!presetn)
    wr_diag |=> diag_sw.terminal_fault_check_enable == $past(pwdata[cmdac_pkg::FCHK_BIT]))
    else $error("fault check enable does not follow write");

  a_odd_term_follow: assert property (@(posedge pclk) disable iff (!presetn)
    wr_diag |=> diag_sw.odd_terminal_probe_switch == $past(pwdata[cmdac_pkg::ODD_T_BIT]))
    else $error("odd terminal switch does not follow write");

  a_even_term_follow: assert property (@(posedge pclk) disable iff (!presetn)
    wr_diag |=> diag_sw.even_terminal_probe_switch == $past(pwdata[cmdac_pkg::EVEN_T_BIT]))
    else $error("even terminal switch does not follow write");

  a_balance_sw_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_diag |=> $stable(diag_sw.odd_balance_probe_switch) && $stable(diag_sw.even_balance_probe_switch))
    else $error("balance switch moved without a write");

  a_kick_starts_busy: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_kick |=> s_busy_start ##1 (conv_busy && !conv_start))
    else $error("kickoff did not start one conversion");

  a_zero_kick_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_setup && !pwdata[cmdac_pkg::KICK_BIT] && conv_busy && !sample_valid) |=> conv_busy)
    else $error("writing kickoff 0 disturbed a running conversion");

  a_read_busy_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && hit_setup && mapped) |=> prdata[cmdac_pkg::KICK_BIT] == $past(conv_busy)
      && !prdata[cmdac_pkg::CLEAR_BIT])
    else $error("setup read returns wrong busy or bit 7");

  a_avg_count_end: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(conv_busy) |-> $past(cnt_q) == 9'(target - 9'h001))
    else $error("conversion ended after wrong sample count");

  a_clear_one_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (cc_clr && !$past(cc_clr)) |=> charge_counter_clear ##1 (charge_counter_clear == $past(cc_clr)))
    else $error("charge counter clear is not a write-driven pulse");

  a_done_sets_irq: assert property (@(posedge pclk) disable iff (!presetn)
    (done && en_q[cmdac_pkg::IRQ_DONE_BIT]) |=> stat_q[cmdac_pkg::IRQ_DONE_BIT] && irq)
    else $error("completion did not raise interrupt");

  a_clear_sets_status: assert property (@(posedge pclk) disable iff (!presetn)
    cc_clr |=> stat_q[cmdac_pkg::IRQ_CLR_BIT])
    else $error("charge counter clear did not set its status bit");

  a_busy_kick_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_setup && pwdata[cmdac_pkg::KICK_BIT] && conv_busy) |=> !conv_start)
    else $error("kickoff while busy restarted the conversion");

  a_gain_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_setup |=> conv_cfg.amp_gain_select == $past(pwdata[cmdac_pkg::GAIN_LSB +: 3]))
    else $error("gain select does not follow setup write");

  a_reset_sw_open: assert property (@(posedge pclk)
    $rose(presetn) |-> diag_sw == '0)
    else $error("probe switches not open after reset");

endmodule : cmdac_top

// ==== testbench/cmdac_top_bench.sv ====
`timescale 1ns/1ns
module cmdac_top_bench;
  localparam logic [11:0] A_SETUP = 12'({cmdac_pkg::SETUP_IDX, 2'b00});
  localparam logic [11:0] A_DIAG  = 12'({cmdac_pkg::DIAG_IDX, 2'b00});
  localparam logic [11:0] A_RES   = 12'({cmdac_pkg::RESULT_IDX, 2'b00});
  localparam logic [11:0] A_STAT  = 12'({cmdac_pkg::IRQ_STAT_IDX, 2'b00});
  localparam logic [11:0] A_EN    = 12'({cmdac_pkg::IRQ_EN_IDX, 2'b00});
  localparam logic [11:0] A_CLR   = 12'({cmdac_pkg::IRQ_CLR_IDX, 2'b00});
  logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata;
  logic                   sample_valid, conv_start, conv_busy, charge_counter_clear, irq;
  logic [15:0]            sample_data, conv_result;
  logic [2:0]             amp_gain_report;
  cmdac_pkg::cmdac_diag_t diag_sw;
  cmdac_pkg::cmdac_cfg_t  conv_cfg;
  int                     n_mismatch, num_checks;

  cmdac_top i_cmdac_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_data(sample_data), .amp_gain_report(amp_gain_report),
    .diag_sw(diag_sw), .conv_cfg(conv_cfg), .conv_start(conv_start), .conv_busy(conv_busy),
    .conv_result(conv_result), .charge_counter_clear(charge_counter_clear), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // Request held from setup until the edge where pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16)
    begin
      n_mismatch++;
      $display("ERROR %0t bus answer missing", $time);
      end_of_test();
    end
    else
    begin
      r = prdata; e = pslverr; psel <= 1'b0; penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    check({31'h0, e}, {31'h0, xe}, "write error flag");
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, x, "read data");
    check({31'h0, e}, {31'h0, xe}, "read error flag");
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(A_SETUP, 32'h0000_0417, 1'b0);
    check({27'h0, diag_sw}, 32'h0, "switches at reset");
    check({23'h0, conv_cfg}, 32'h117, "config at reset");
    rd(A_DIAG, 32'h0, 1'b0);
  endtask : t_reset

  // One switch at a time keeps odd and even probes apart and fault check off while probing
  task automatic t_diag();
    for (int b = 0; b < 5; b++)
    begin
      wr(A_DIAG, 32'h1 << b, 1'b0);
      #1 check({27'h0, diag_sw}, 32'h1 << b, "switch drive");
      rd(A_DIAG, 32'h1 << b, 1'b0);
    end
    wr(A_DIAG, 32'h0, 1'b0);
    #1 check({27'h0, diag_sw}, 32'h0, "switches open");
  endtask : t_diag

  task automatic t_conv(input logic [3:0] code);
    int          n, sh, sum;
    logic [15:0] smp;
    sh = (code >= 4'h1 && code <= cmdac_pkg::AVG_MAX_CODE) ? int'(code) : 0;
    n = 1 << sh;
    sum = 0;
    wr(A_SETUP, {16'h0, code, 1'b1, 3'b010, 2'b00, 6'h17}, 1'b0);
    #1 check({30'h0, conv_start, conv_busy}, 32'h3, "start and busy");
    check({23'h0, conv_cfg}, 32'h097, "config fields");
    if (code == 4'h2)
    begin
      rd(A_SETUP, {16'h0, code, 1'b1, 3'b011, 2'b00, 6'h17}, 1'b0);
      wr(A_SETUP, {16'h0, code, 1'b0, 3'b010, 2'b00, 6'h17}, 1'b0);
      wr(A_SETUP, {16'h0, code, 1'b1, 3'b010, 2'b00, 6'h17}, 1'b0);
      #1 check({30'h0, conv_start, conv_busy}, 32'h1, "no restart while busy");
    end
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      check({31'h0, conv_busy}, 32'h1, "busy while sampling");
      smp = 16'h1000 + 16'(i * 7);
      sum += int'(smp);
      sample_valid <= 1'b1;
      sample_data <= smp;
    end
    @(posedge pclk);
    sample_valid <= 1'b0;
    #1 check({31'h0, conv_busy}, 32'h0, "busy after last sample");
    check({16'h0, conv_result}, 32'(sum >> sh), "averaged result");
    rd(A_RES, 32'(sum >> sh), 1'b0);
  endtask : t_conv

  task automatic t_clear();
    wr(A_CLR, 32'h3, 1'b0);
    wr(A_SETUP, {16'h0, 4'h0, 1'b0, 3'b010, 1'b1, 1'b0, 6'h17}, 1'b0);
    #1 check({31'h0, charge_counter_clear}, 32'h1, "clear pulse");
    @(posedge pclk);
    #1 check({31'h0, charge_counter_clear}, 32'h0, "clear pulse ends");
    rd(A_STAT, 32'h2, 1'b0);
    wr(A_SETUP, {16'h0, 4'h0, 1'b0, 3'b010, 1'b0, 1'b0, 6'h17}, 1'b0);
    #1 check({31'h0, charge_counter_clear}, 32'h0, "no clear on zero");
  endtask : t_clear

  // Status bit 1 stays set but unmasked only bit 0 may raise the line
  task automatic t_irq();
    wr(A_EN, 32'h0, 1'b0);
    wr(A_CLR, 32'h1, 1'b0);
    t_conv(4'h0);
    repeat (2) @(posedge pclk);
    #1 check({31'h0, irq}, 32'h0, "irq masked");
    wr(A_EN, 32'h1, 1'b0);
    repeat (2) @(posedge pclk);
    #1 check({31'h0, irq}, 32'h1, "irq raised");
    rd(A_STAT, 32'h3, 1'b0);
    wr(A_CLR, 32'h1, 1'b0);
    repeat (2) @(posedge pclk);
    #1 check({31'h0, irq}, 32'h0, "irq cleared");
    rd(A_STAT, 32'h2, 1'b0);
    t_conv(4'h1);
    repeat (2) @(posedge pclk);
    #1 check({31'h0, irq}, 32'h1, "irq on completion");
    rd(A_STAT, 32'h3, 1'b0);
    rd(A_CLR, 32'h0, 1'b0);
  endtask : t_irq

  // A reset in mid-run must open every switch and drop the interrupt state
  task automatic t_midreset();
    wr(A_DIAG, 32'h0000_001a, 1'b0);
    wr(A_EN, 32'h0000_0003, 1'b0);
    @(posedge pclk);
    #1 check({27'h0, diag_sw}, 32'h0000_001a, "switches before reset");
    check({31'h0, irq}, 32'h1, "irq before reset");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1 check({27'h0, diag_sw}, 32'h0, "switches after reset");
    check({31'h0, irq}, 32'h0, "irq after reset");
    check({23'h0, conv_cfg}, 32'h0000_0117, "config after reset");
    @(posedge pclk);
    presetn <= 1'b1;
    rd(A_SETUP, 32'h0000_0317, 1'b0);
    rd(A_DIAG, 32'h0, 1'b0);
    rd(A_STAT, 32'h0, 1'b0);
    rd(A_EN, 32'h0, 1'b0);
  endtask : t_midreset

  task automatic t_errors();
    rd(12'h03c, 32'h0, 1'b1);
    wr(12'h034, 32'hffff_ffff, 1'b1);
    rd(12'h01a, 32'h0, 1'b1);
    rd(12'h418, 32'h0, 1'b1);
  endtask : t_errors

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    sample_valid = 1'b0; sample_data = 16'h0000; amp_gain_report = 3'b100;
    n_mismatch = 0; num_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_diag();
    amp_gain_report <= 3'b011;
    for (int c = 0; c < 16; c++)
      t_conv(4'(c));
    t_clear();
    t_irq();
    t_midreset();
    t_errors();
    end_of_test();
  end
endmodule : cmdac_top_bench
